// *** pkg/rsl_defines.svh ***
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH

// ------------------------------------------------------------
// strap encodings and reset values
// ------------------------------------------------------------
`define RSL_BOOT_DEST_SPI    1'b0
`define RSL_BOOT_DEST_LPC    1'b1
`define RSL_EC_IF_LPC        1'b0
`define RSL_EC_IF_ESPI       1'b1
`define RSL_RSVD_PU_LEVEL    1'b1
`define RSL_RSVD_PD_LEVEL    1'b0
`define RSL_SW_BOOT_DEST_BIT 6
`define RSL_SW_BOOT_DEST_OFS 8'hbc
`define RSL_PULL_ON          1'b1
`define RSL_PULL_OFF         1'b0
`define RSL_FLAG_CLR         1'b0

// ------------------------------------------------------------
// positions of the pins in the synchroniser bank
// ------------------------------------------------------------
`define RSL_IDX_FLASH_IO3    0
`define RSL_IDX_FLASH_IO2    1
`define RSL_IDX_FLASH_IN     2
`define RSL_IDX_FLASH_OUT    3
`define RSL_IDX_THERMAL      4
`define RSL_IDX_EC_STRAP     5
`define RSL_IDX_BOOT_STRAP   6
`define RSL_IDX_PLT_RST_N    7
`define RSL_IDX_RSM_RST_N    8
`define RSL_IDX_PWR_GOOD     9

`endif

// *** pkg/rsl_pkg.sv ***
package rsl_pkg;

   // -------------------------------------------------------------
   // destination of a bios range access
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      RSL_ROUTE_SPI = 2'b01,
      RSL_ROUTE_LPC = 2'b10
   } rsl_route_e;

endpackage

// *** rtl/rsl_edge_sync.sv ***
`timescale 1ns/1ps
`include "rsl_defines.svh"

// ------------------------------------------------------------
// three-stage synchroniser with rising and falling edge detect
// ------------------------------------------------------------
module rsl_edge_sync (
   // clock and reset
   input  wire logic SYS_CLK,
   input  wire logic RST,
   // async level in
   input  wire logic async_in,
   // synchronised level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic       level_q;
   logic       level_d;
   logic       agree;

   // a change counts only once stages two and three hold the same value
   always_comb begin
      sync_d  = {sync_q[1:0], async_in};
      agree   = (sync_q[1] == sync_q[2]);
      level_d = agree ? sync_q[2] : level_q;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sync_q  <= 3'h0;
         level_q <= `RSL_FLAG_CLR;
      end else begin
         sync_q  <= sync_d;
         level_q <= level_d;
      end
   end

   // stage one is read by stage two only
   assign level = level_q;
   assign rise  = level_d & ~level_q;
   assign fall  = ~level_d & level_q;

endmodule // rsl_edge_sync

// *** rtl/rsl_reset_strap_latch.sv ***
`timescale 1ns/1ps
`include "rsl_defines.svh"

// Contract
// - latch boot destination on power-good rise; 0 spi, 1 lpc.
// - software bit also selects boot destination, same encoding.
// - boot strap pull-down on until platform reset deasserts.
// - engine and network spi accesses always go to spi.
// - latch ec interface strap on resume reset rise; 0 lpc, 1 espi.
// - ec strap pull-down off once resume reset deasserts.
// - after sampling, pins return to normal use, values kept.
module rsl_reset_strap_latch (
   // clock and reset
   input  wire logic SYS_CLK,
   input  wire logic RST,
   // reset and power-good pins
   input  wire logic PLATFORM_POWER_GOOD,
   input  wire logic RESUME_WELL_RESET_N,
   input  wire logic PLATFORM_RESET_N,
   // strap pins
   input  wire logic BOOT_DEST_STRAP_PIN,
   input  wire logic EC_INTERFACE_STRAP_PIN,
   input  wire logic THERMAL_ALERT_RESERVED_STRAP,
   input  wire logic FLASH_OUT_RESERVED_STRAP,
   input  wire logic FLASH_IN_RESERVED_STRAP,
   input  wire logic FLASH_IO2_RESERVED_STRAP,
   input  wire logic FLASH_IO3_RESERVED_STRAP,
   // software boot destination control
   input  wire logic SW_BOOT_DEST_WR,
   input  wire logic SW_BOOT_DEST,
   // bios range access request
   input  wire logic BIOS_ACCESS,
   input  wire logic ACCESS_FROM_ENGINE,
   // outputs
   output logic      BOOT_DESTINATION_STRAP,
   output logic      BOOT_DEST_EFFECTIVE,
   output logic      ROUTE_TO_SPI,
   output logic      ROUTE_TO_LPC,
   output logic      EC_INTERFACE_ESPI,
   output logic      BOOT_DEST_PULLDOWN_EN,
   output logic      EC_STRAP_PULLDOWN_EN,
   output logic      RESERVED_PULLUP_EN,
   output logic      THERMAL_PULLDOWN_EN,
   output logic      STRAP_FUNCTIONAL,
   output logic      RESERVED_STRAP_ERR
);

   // -------------------------------------------------------------
   // synchronisers
   // -------------------------------------------------------------
   localparam int N = 10;
   logic [N-1:0] raw;
   logic [N-1:0] lvl;
   logic [N-1:0] rise;
   logic [N-1:0] fall;

   // one synchroniser per pin; each reserved strap is synchronised on its own, all five feed one error flag
   assign raw[`RSL_IDX_PWR_GOOD]   = PLATFORM_POWER_GOOD;
   assign raw[`RSL_IDX_RSM_RST_N]  = RESUME_WELL_RESET_N;
   assign raw[`RSL_IDX_PLT_RST_N]  = PLATFORM_RESET_N;
   assign raw[`RSL_IDX_BOOT_STRAP] = BOOT_DEST_STRAP_PIN;
   assign raw[`RSL_IDX_EC_STRAP]   = EC_INTERFACE_STRAP_PIN;
   assign raw[`RSL_IDX_THERMAL]    = THERMAL_ALERT_RESERVED_STRAP;
   assign raw[`RSL_IDX_FLASH_OUT]  = FLASH_OUT_RESERVED_STRAP;
   assign raw[`RSL_IDX_FLASH_IN]   = FLASH_IN_RESERVED_STRAP;
   assign raw[`RSL_IDX_FLASH_IO2]  = FLASH_IO2_RESERVED_STRAP;
   assign raw[`RSL_IDX_FLASH_IO3]  = FLASH_IO3_RESERVED_STRAP;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_sync
         rsl_edge_sync u_sync (
            .SYS_CLK  (SYS_CLK),
            .RST      (RST),
            .async_in (raw[gi]),
            .level    (lvl[gi]),
            .rise     (rise[gi]),
            .fall     (fall[gi])
         );
      end
   endgenerate

   logic pwr_rise;
   logic rsm_rise;
   logic rsm_fall;
   logic plt_rise;
   assign pwr_rise = rise[`RSL_IDX_PWR_GOOD];
   assign rsm_rise = rise[`RSL_IDX_RSM_RST_N];
   assign rsm_fall = fall[`RSL_IDX_RSM_RST_N];
   assign plt_rise = rise[`RSL_IDX_PLT_RST_N];

   // -------------------------------------------------------------
   // decoders
   // -------------------------------------------------------------
   // true when every reserved strap sits at its required level
   function automatic logic rsvd_ok(input logic [N-1:0] l);
      logic hi;
      logic lo;
      hi = (l[`RSL_IDX_FLASH_OUT] == `RSL_RSVD_PU_LEVEL)
         & (l[`RSL_IDX_FLASH_IN]  == `RSL_RSVD_PU_LEVEL)
         & (l[`RSL_IDX_FLASH_IO2] == `RSL_RSVD_PU_LEVEL)
         & (l[`RSL_IDX_FLASH_IO3] == `RSL_RSVD_PU_LEVEL);
      lo = (l[`RSL_IDX_THERMAL] == `RSL_RSVD_PD_LEVEL);
      return hi & lo;
   endfunction

   // engine and network fetches ignore the host's boot destination
   function automatic rsl_pkg::rsl_route_e route_of(input logic dest,
                                                   input logic eng);
      rsl_pkg::rsl_route_e r;
      if (eng) begin
         r = rsl_pkg::RSL_ROUTE_SPI;
      end else if (dest == `RSL_BOOT_DEST_LPC) begin
         r = rsl_pkg::RSL_ROUTE_LPC;
      end else begin
         r = rsl_pkg::RSL_ROUTE_SPI;
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // latched state
   // -------------------------------------------------------------
   logic boot_strap_q, boot_strap_d;
   logic sw_dest_q,    sw_dest_d;
   logic ec_if_q,      ec_if_d;
   logic rsvd_err_q,   rsvd_err_d;
   logic boot_pd_q,    boot_pd_d;
   logic ec_pd_q,      ec_pd_d;
   logic spi_q,        spi_d;
   logic lpc_q,        lpc_d;

   always_comb begin
      boot_strap_d = boot_strap_q;
      sw_dest_d    = sw_dest_q;
      ec_if_d      = ec_if_q;
      rsvd_err_d   = rsvd_err_q;
      // held until next sampling edge; sw_dest_q also takes software writes
      if (pwr_rise) begin
         boot_strap_d = lvl[`RSL_IDX_BOOT_STRAP];
         sw_dest_d    = lvl[`RSL_IDX_BOOT_STRAP];
      end else if (SW_BOOT_DEST_WR) begin
         // a write racing the strap edge is lost; the strap wins
         sw_dest_d    = SW_BOOT_DEST;
      end
      if (rsm_rise) begin
         ec_if_d      = lvl[`RSL_IDX_EC_STRAP];
         rsvd_err_d   = ~rsvd_ok(lvl);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         boot_strap_q <= `RSL_BOOT_DEST_SPI;
         sw_dest_q    <= `RSL_BOOT_DEST_SPI;
         ec_if_q      <= `RSL_EC_IF_LPC;
         rsvd_err_q   <= `RSL_FLAG_CLR;
      end else begin
         boot_strap_q <= boot_strap_d;
         sw_dest_q    <= sw_dest_d;
         ec_if_q      <= ec_if_d;
         rsvd_err_q   <= rsvd_err_d;
      end
   end

   // -------------------------------------------------------------
   // strap pull control
   // -------------------------------------------------------------
   always_comb begin
      boot_pd_d = boot_pd_q;
      ec_pd_d   = ec_pd_q;
      if (pwr_rise) begin
         boot_pd_d = `RSL_PULL_ON;
      end
      // release wins over a fresh power-good edge in the same cycle
      if (plt_rise) begin
         boot_pd_d = `RSL_PULL_OFF;
      end
      if (rsm_rise) begin
         ec_pd_d   = `RSL_PULL_OFF;
      end else if (rsm_fall) begin
         // re-armed for the next resume-well sampling window
         ec_pd_d   = `RSL_PULL_ON;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         boot_pd_q <= `RSL_PULL_ON;
         ec_pd_q   <= `RSL_PULL_ON;
      end else begin
         boot_pd_q <= boot_pd_d;
         ec_pd_q   <= ec_pd_d;
      end
   end

   // -------------------------------------------------------------
   // access routing
   // -------------------------------------------------------------
   rsl_pkg::rsl_route_e route_now;

   always_comb begin
      route_now = route_of(sw_dest_q, ACCESS_FROM_ENGINE);
      spi_d     = BIOS_ACCESS & (route_now == rsl_pkg::RSL_ROUTE_SPI);
      lpc_d     = BIOS_ACCESS & (route_now == rsl_pkg::RSL_ROUTE_LPC);
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         spi_q <= `RSL_FLAG_CLR;
         lpc_q <= `RSL_FLAG_CLR;
      end else begin
         spi_q <= spi_d;
         lpc_q <= lpc_d;
      end
   end

   assign BOOT_DESTINATION_STRAP = boot_strap_q;
   assign BOOT_DEST_EFFECTIVE    = sw_dest_q;
   assign ROUTE_TO_SPI           = spi_q;
   assign ROUTE_TO_LPC           = lpc_q;
   assign EC_INTERFACE_ESPI      = ec_if_q;
   assign BOOT_DEST_PULLDOWN_EN  = boot_pd_q;
   assign EC_STRAP_PULLDOWN_EN   = ec_pd_q;
   // reserved pulls follow the resume-well sampling window
   assign RESERVED_PULLUP_EN     = ec_pd_q;
   assign THERMAL_PULLDOWN_EN    = ec_pd_q;
   assign STRAP_FUNCTIONAL       = ~boot_pd_q & ~ec_pd_q;
   assign RESERVED_STRAP_ERR     = rsvd_err_q;

endmodule // rsl_reset_strap_latch

// *** testbench/rsl_board.sv ***
`timescale 1ns/1ps
module rsl_board (
   input  wire logic [2:0] BAD,
   input  wire logic       BOOT_V, EC_V,
   output logic BOOT_DEST_STRAP_PIN, EC_INTERFACE_STRAP_PIN,
   output logic THERMAL_ALERT_RESERVED_STRAP, FLASH_OUT_RESERVED_STRAP,
   output logic FLASH_IN_RESERVED_STRAP, FLASH_IO2_RESERVED_STRAP,
   output logic FLASH_IO3_RESERVED_STRAP
);
   // firm resistors; bench sets them well ahead of sampling
   assign BOOT_DEST_STRAP_PIN = BOOT_V;
   assign EC_INTERFACE_STRAP_PIN = EC_V;
   // bad 1, 3, 4, 5 pull a high strap low
   // bad 2 lifts the low one; 6 and 7 are clean boards
   assign FLASH_OUT_RESERVED_STRAP = (BAD != 3'h1);
   assign FLASH_IN_RESERVED_STRAP = (BAD != 3'h3);
   assign FLASH_IO2_RESERVED_STRAP = (BAD != 3'h4);
   assign FLASH_IO3_RESERVED_STRAP = (BAD != 3'h5);
   assign THERMAL_ALERT_RESERVED_STRAP = (BAD == 3'h2);
   // flash with a valid descriptor taken as fitted
endmodule // rsl_board

// *** testbench/rsl_reset_strap_latch_assertions.sv ***
`timescale 1ns/1ps
module rsl_reset_strap_latch_chk (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // reset and power-good pins
   input wire logic PLATFORM_POWER_GOOD,
   input wire logic RESUME_WELL_RESET_N,
   input wire logic PLATFORM_RESET_N,
   // strap pins
   input wire logic BOOT_DEST_STRAP_PIN,
   input wire logic EC_INTERFACE_STRAP_PIN,
   input wire logic THERMAL_ALERT_RESERVED_STRAP,
   input wire logic FLASH_OUT_RESERVED_STRAP,
   input wire logic FLASH_IN_RESERVED_STRAP,
   input wire logic FLASH_IO2_RESERVED_STRAP,
   input wire logic FLASH_IO3_RESERVED_STRAP,
   // requests
   input wire logic SW_BOOT_DEST_WR,
   input wire logic SW_BOOT_DEST,
   input wire logic ACCESS_FROM_ENGINE,
   input wire logic BIOS_ACCESS,
   // design outputs
   input wire logic BOOT_DESTINATION_STRAP,
   input wire logic BOOT_DEST_EFFECTIVE,
   input wire logic ROUTE_TO_SPI,
   input wire logic ROUTE_TO_LPC,
   input wire logic EC_INTERFACE_ESPI,
   input wire logic BOOT_DEST_PULLDOWN_EN,
   input wire logic EC_STRAP_PULLDOWN_EN,
   input wire logic RESERVED_STRAP_ERR
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // cycles since any sampling edge, saturating
   logic [2:0] age_q;
   logic       pg_q;
   logic       rw_q;
   always_ff @(posedge SYS_CLK) begin
      pg_q <= PLATFORM_POWER_GOOD;
      rw_q <= RESUME_WELL_RESET_N;
      if (RST || (PLATFORM_POWER_GOOD && !pg_q)
          || (RESUME_WELL_RESET_N && !rw_q))
         age_q <= 3'h0;
      else if (age_q != 3'h7)
         age_q <= age_q + 3'h1;
   end
   // ##6 leaves room for the sync stages; pins stay put meanwhile
   property p_boot;
      $rose(PLATFORM_POWER_GOOD) |-> ##6 (BOOT_DESTINATION_STRAP ==
         BOOT_DEST_STRAP_PIN && BOOT_DEST_EFFECTIVE == BOOT_DEST_STRAP_PIN);
   endproperty
   a_boot: assert property (p_boot) else $error("boot latch");
   property p_sw;
      SW_BOOT_DEST_WR |-> ##2 BOOT_DEST_EFFECTIVE == $past(SW_BOOT_DEST, 2);
   endproperty
   a_sw: assert property (p_sw) else $error("sw select");
   property p_bpull;
      $rose(PLATFORM_RESET_N) |-> ##6 !BOOT_DEST_PULLDOWN_EN;
   endproperty
   a_bpull: assert property (p_bpull) else $error("boot pull");
   property p_eng;
      BIOS_ACCESS && ACCESS_FROM_ENGINE |=> ROUTE_TO_SPI && !ROUTE_TO_LPC;
   endproperty
   a_eng: assert property (p_eng) else $error("engine route");
   property p_ec;
      $rose(RESUME_WELL_RESET_N) |-> ##6
         EC_INTERFACE_ESPI == EC_INTERFACE_STRAP_PIN;
   endproperty
   a_ec: assert property (p_ec) else $error("ec latch");
   property p_epull;
      $rose(RESUME_WELL_RESET_N) |-> ##6 !EC_STRAP_PULLDOWN_EN;
   endproperty
   a_epull: assert property (p_epull) else $error("ec pull");
   property p_rsvd;
      $rose(RESUME_WELL_RESET_N) |-> ##6 RESERVED_STRAP_ERR ==
         (!FLASH_OUT_RESERVED_STRAP || !FLASH_IN_RESERVED_STRAP
          || !FLASH_IO2_RESERVED_STRAP || !FLASH_IO3_RESERVED_STRAP
          || THERMAL_ALERT_RESERVED_STRAP);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   property p_hold;
      age_q == 3'h7 |-> $stable(BOOT_DESTINATION_STRAP)
         && $stable(EC_INTERFACE_ESPI);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved");
   c_boot: cover property ($rose(PLATFORM_POWER_GOOD));
   c_ec: cover property ($rose(RESUME_WELL_RESET_N));
   c_sw: cover property (SW_BOOT_DEST_WR && SW_BOOT_DEST);
endmodule // rsl_reset_strap_latch_chk
bind rsl_reset_strap_latch rsl_reset_strap_latch_chk u_chk (.*);

// *** testbench/rsl_reset_strap_latch_tb.sv ***
`timescale 1ns/1ps
module rsl_reset_strap_latch_tb;
   logic SYS_CLK = 1'b0, RST = 1'b1, PLATFORM_POWER_GOOD = 1'b0;
   logic RESUME_WELL_RESET_N = 1'b0, PLATFORM_RESET_N = 1'b0;
   logic SW_BOOT_DEST_WR = 1'b0, SW_BOOT_DEST = 1'b0, BIOS_ACCESS = 1'b0;
   logic ACCESS_FROM_ENGINE = 1'b0, BOOT_V = 1'b0, EC_V = 1'b0;
   logic [2:0] BAD = 3'h0;
   logic BOOT_DEST_STRAP_PIN, EC_INTERFACE_STRAP_PIN, STRAP_FUNCTIONAL;
   logic THERMAL_ALERT_RESERVED_STRAP, FLASH_OUT_RESERVED_STRAP;
   logic FLASH_IN_RESERVED_STRAP, FLASH_IO2_RESERVED_STRAP;
   logic FLASH_IO3_RESERVED_STRAP, BOOT_DESTINATION_STRAP, ROUTE_TO_SPI;
   logic BOOT_DEST_EFFECTIVE, ROUTE_TO_LPC, EC_INTERFACE_ESPI;
   logic BOOT_DEST_PULLDOWN_EN, EC_STRAP_PULLDOWN_EN, RESERVED_PULLUP_EN;
   logic THERMAL_PULLDOWN_EN, RESERVED_STRAP_ERR, lpc;
   int error_cnt = 0, compares = 0, cyc = 0, i, j;
   integer seed = 32'hc04edf62;
   rsl_reset_strap_latch dut (.*);
   rsl_board board (.*);
   always #4 SYS_CLK = ~SYS_CLK;
   task automatic chk(input logic s, input logic e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic w(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask
   function automatic logic exp_lpc(input logic d, input logic eng);
      return d & ~eng;
   endfunction
   // board codes 1 to 5 put one reserved strap off its level
   function automatic logic exp_err(input logic [2:0] b);
      return (b != 3'h0) && (b < 3'h6);
   endfunction
   initial begin
      w(2);
      RST = 1'b0;
      w(1);
      for (i = 0; i < 8; i++) begin
         {PLATFORM_POWER_GOOD, RESUME_WELL_RESET_N, PLATFORM_RESET_N} = 3'h0;
         BOOT_V = (i < 2) ? i[0] : 1'($random(seed));
         EC_V = 1'($random(seed));
         BAD = i[2:0];
         // sixteen cycles covers four slow bus clocks
         w(16);
         chk(EC_STRAP_PULLDOWN_EN, 1'b1);
         chk(RESERVED_PULLUP_EN, 1'b1);
         chk(THERMAL_PULLDOWN_EN, 1'b1);
         {PLATFORM_POWER_GOOD, RESUME_WELL_RESET_N} = 2'h3;
         w(8);
         chk(BOOT_DESTINATION_STRAP, BOOT_V);
         chk(BOOT_DEST_EFFECTIVE, BOOT_V);
         chk(EC_INTERFACE_ESPI, EC_V);
         chk(EC_STRAP_PULLDOWN_EN, 1'b0);
         chk(RESERVED_PULLUP_EN, 1'b0);
         chk(THERMAL_PULLDOWN_EN, 1'b0);
         chk(BOOT_DEST_PULLDOWN_EN, 1'b1);
         chk(STRAP_FUNCTIONAL, 1'b0);
         chk(RESERVED_STRAP_ERR, exp_err(BAD));
         PLATFORM_RESET_N = 1'b1;
         w(8);
         chk(BOOT_DEST_PULLDOWN_EN, 1'b0);
         chk(STRAP_FUNCTIONAL, 1'b1);
         {BOOT_V, EC_V} = ~{BOOT_V, EC_V};
         w(8);
         chk(BOOT_DESTINATION_STRAP, ~BOOT_V);
         chk(EC_INTERFACE_ESPI, ~EC_V);
         SW_BOOT_DEST = 1'($random(seed));
         SW_BOOT_DEST_WR = 1'b1;
         w(1);
         SW_BOOT_DEST_WR = 1'b0;
         w(2);
         chk(BOOT_DEST_EFFECTIVE, SW_BOOT_DEST);
         for (j = 0; j < 2; j++) begin
            BIOS_ACCESS = 1'b1;
            ACCESS_FROM_ENGINE = j[0];
            lpc = exp_lpc(SW_BOOT_DEST, j[0]);
            w(1);
            chk(ROUTE_TO_LPC, lpc);
            chk(ROUTE_TO_SPI, ~lpc);
         end
         BIOS_ACCESS = 1'b0;
         w(1);
         chk(ROUTE_TO_SPI, 1'b0);
         chk(ROUTE_TO_LPC, 1'b0);
      end
      close_out();
   end
endmodule // rsl_reset_strap_latch_tb
